// ---- idr_fos_monitor.sv ----
// Frequency offset alarm for one clock input against its rate code
`default_nettype none
`include "idr_regs.svh"
module idr_fos_monitor #(
	parameter int FREQ_W = 10
)(
	input  wire logic                  clock_i,
	input  wire logic                  arst_n_i,
	input  wire idr_pkg::idr_rate_type rate_code_i,
	input  wire logic [FREQ_W-1:0]     freq_mhz_i,
	output logic                       frequency_offset_alarm_o
);

	////////////////////////////////////////////////////////////////////
	// Range lookup, MHz
	function automatic logic out_of_range(
		input idr_pkg::idr_rate_type code,
		input logic [FREQ_W-1:0]     f
	);
		logic [10:0] lo;
		logic [10:0] hi;
		lo = 11'h000;
		hi = 11'h7FF;
		case (code)
			3'h0:    lo = 11'h00A;
			3'h1:    lo = 11'h019;
			3'h2:    lo = 11'h032;
			3'h3:    lo = 11'h05F;
			3'h4:    lo = 11'h0BE;
			3'h5:    lo = 11'h177;
			default: lo = 11'h000;
		endcase
		case (code)
			3'h0:    hi = 11'h01B;
			3'h1:    hi = 11'h036;
			3'h2:    hi = 11'h069;
			3'h3:    hi = 11'h0D7;
			3'h4:    hi = 11'h1B3;
			3'h5:    hi = 11'h2C6;
			default: hi = 11'h7FF;
		endcase
		out_of_range = (11'(f) < lo) || (11'(f) > hi);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Alarm flop
	wire logic next_alarm;
	assign next_alarm = out_of_range(rate_code_i, freq_mhz_i);

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			frequency_offset_alarm_o <= 1'b0;
		else
			frequency_offset_alarm_o <= next_alarm;
	end

endmodule // idr_fos_monitor
`default_nettype wire

// ---- idr_pkg.sv ----
// Types shared by the divider bank and the offset monitor
`default_nettype none
package idr_pkg;
	typedef logic [18:0] idr_div_type;
	typedef logic [19:0] idr_ratio_type;
	typedef logic [2:0]  idr_rate_type;
endpackage
`default_nettype wire

// ---- idr_regs.svh ----
// Register offsets, reset values and field positions of the divider bank
`ifndef IDR_REGS_SVH
`define IDR_REGS_SVH

`define IDR_IN1_DIV_HIGH     8'h2B
`define IDR_IN1_DIV_MID      8'h2C
`define IDR_IN1_DIV_LOW      8'h2D
`define IDR_IN2_DIV_HIGH     8'h2E
`define IDR_IN2_DIV_MID      8'h2F
`define IDR_IN2_DIV_LOW      8'h30
`define IDR_IN3_DIV_HIGH     8'h31
`define IDR_IN3_DIV_MID      8'h32
`define IDR_IN3_DIV_LOW      8'h33
`define IDR_IN4_DIV_HIGH     8'h34
`define IDR_IN4_DIV_MID      8'h35
`define IDR_IN4_DIV_LOW      8'h36
`define IDR_RATE_IN1_IN2     8'h37
`define IDR_RATE_IN3_IN4     8'h38
`define IDR_DIV_BYTES        8'h03

`define IDR_DIV_HIGH_RST     3'h0
`define IDR_DIV_MID_RST      8'h00
`define IDR_DIV_LOW_RST      8'h09
`define IDR_DIV_RST          19'h00009
`define IDR_RATIO_RST        20'h0000A
`define IDR_RATE_RST         3'h0

`define IDR_RATE_LO_LSB      0
`define IDR_RATE_HI_LSB      3
`define IDR_RATE_RESERVED    3'h6

`endif

// ---- idr_regs_bank.sv ----
// Input divider and rate range register bank with offset alarms
//
// Notes on behaviour
// - Second input holds 19-bit ratio, three bytes
// - Third input holds 19-bit ratio, high first
// - Fourth input ratio equals stored value plus one
// - Reset: low bytes 0x09, others zero
// - Three-bit rate codes, two per register
// - First input holds 19-bit ratio, three bytes
// - Alarm when input leaves selected rate range
`default_nettype none
`include "idr_regs.svh"
module idr_regs_bank #(
	parameter int FREQ_W = 10
)(
	input  wire logic                          clock_i,
	input  wire logic                          arst_n_i,
	input  wire logic [7:0]                    reg_addr_i,
	input  wire logic [7:0]                    reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic [3:0][FREQ_W-1:0]        freq_mhz_i,
	output logic      [7:0]                    reg_rdata_o,
	output idr_pkg::idr_div_type   [3:0]       divider_value_o,
	output idr_pkg::idr_ratio_type [3:0]       divide_ratio_o,
	output idr_pkg::idr_rate_type  [3:0]       rate_code_o,
	output logic      [3:0]                    frequency_offset_alarm_o
);

	////////////////////////////////////////////////////////////////////
	// Address decode
	wire logic [7:0] div_idx;
	wire logic       div_hit;
	wire logic [1:0] div_sel;
	wire logic [1:0] byte_sel;
	wire logic       rate_lo_hit;
	wire logic       rate_hi_hit;

	assign div_idx     = reg_addr_i - `IDR_IN1_DIV_HIGH;
	assign div_hit     = (reg_addr_i >= `IDR_IN1_DIV_HIGH)
		&& (reg_addr_i <= `IDR_IN4_DIV_LOW);
	assign div_sel     = 2'(div_idx / `IDR_DIV_BYTES);
	assign byte_sel    = 2'(div_idx % `IDR_DIV_BYTES);
	assign rate_lo_hit = reg_addr_i == `IDR_RATE_IN1_IN2;
	assign rate_hi_hit = reg_addr_i == `IDR_RATE_IN3_IN4;

	////////////////////////////////////////////////////////////////////
	// Byte access helpers, byte 0 high, 1 mid, 2 low
	function automatic idr_pkg::idr_div_type merge_byte(
		input idr_pkg::idr_div_type d,
		input logic [1:0]           b,
		input logic [7:0]           w
	);
		merge_byte = d;
		case (b)
			2'h0:    merge_byte[18:16] = w[2:0];
			2'h1:    merge_byte[15:8]  = w;
			default: merge_byte[7:0]   = w;
		endcase
	endfunction

	function automatic logic [7:0] read_byte(
		input idr_pkg::idr_div_type d,
		input logic [1:0]           b
	);
		case (b)
			2'h0:    read_byte = {5'h00, d[18:16]};
			2'h1:    read_byte = d[15:8];
			default: read_byte = d[7:0];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Next values
	wire idr_pkg::idr_div_type  [3:0] next_div;
	wire idr_pkg::idr_rate_type [3:0] next_rate;
	wire logic [7:0] next_rdata;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_next
			assign next_div[gi] = (reg_wr_i && div_hit
				&& div_sel == 2'(gi))
				? merge_byte(divider_value_o[gi], byte_sel, reg_wdata_i)
				: divider_value_o[gi];
		end
	endgenerate

	assign next_rate[0] = (reg_wr_i && rate_lo_hit)
		? reg_wdata_i[`IDR_RATE_LO_LSB +: 3] : rate_code_o[0];
	assign next_rate[1] = (reg_wr_i && rate_lo_hit)
		? reg_wdata_i[`IDR_RATE_HI_LSB +: 3] : rate_code_o[1];
	assign next_rate[2] = (reg_wr_i && rate_hi_hit)
		? reg_wdata_i[`IDR_RATE_LO_LSB +: 3] : rate_code_o[2];
	assign next_rate[3] = (reg_wr_i && rate_hi_hit)
		? reg_wdata_i[`IDR_RATE_HI_LSB +: 3] : rate_code_o[3];

	assign next_rdata = !reg_rd_i ? reg_rdata_o
		: div_hit ? read_byte(divider_value_o[div_sel], byte_sel)
		: rate_lo_hit ? {2'h0, rate_code_o[1], rate_code_o[0]}
		: rate_hi_hit ? {2'h0, rate_code_o[3], rate_code_o[2]}
		: 8'h00;

	////////////////////////////////////////////////////////////////////
	// Storage
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < 4; i++)
			begin
				divider_value_o[i] <= `IDR_DIV_RST;
				divide_ratio_o[i]  <= `IDR_RATIO_RST;
				rate_code_o[i]     <= `IDR_RATE_RST;
			end
			reg_rdata_o <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				divider_value_o[i] <= next_div[i];
				divide_ratio_o[i]  <= {1'b0, next_div[i]} + 20'h00001;
				rate_code_o[i]     <= next_rate[i];
			end
			reg_rdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Offset monitors
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_fos
			idr_fos_monitor #(
				.FREQ_W (FREQ_W)
			) u_fos (
				.clock_i                  (clock_i),
				.arst_n_i                 (arst_n_i),
				.rate_code_i              (rate_code_o[gi]),
				.freq_mhz_i               (freq_mhz_i[gi]),
				.frequency_offset_alarm_o (frequency_offset_alarm_o[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Assertions
	logic seen_clock;
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			seen_clock <= 1'b0;
		else
			seen_clock <= 1'b1;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	property p_in2_high;
		reg_wr_i && reg_addr_i == `IDR_IN2_DIV_HIGH
		|=> divider_value_o[1][18:16] == $past(reg_wdata_i[2:0]);
	endproperty
	a_in2_high: assert property (p_in2_high)
		else $error("second input high bits not written");

	property p_in3_mid;
		reg_wr_i && reg_addr_i == `IDR_IN3_DIV_MID
		|=> divider_value_o[2][15:8] == $past(reg_wdata_i)
			&& $stable(divider_value_o[2][7:0]);
	endproperty
	a_in3_mid: assert property (p_in3_mid)
		else $error("third input middle byte wrong");

	property p_in4_ratio;
		divide_ratio_o[3] == {1'b0, divider_value_o[3]} + 20'h00001;
	endproperty
	a_in4_ratio: assert property (p_in4_ratio)
		else $error("fourth input ratio is not value plus one");

	property p_reset_low;
		!seen_clock |-> divider_value_o[0][7:0] == `IDR_DIV_LOW_RST
			&& divider_value_o[3][18:8] == 11'h000;
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("divider reset value wrong");

	property p_rate_pair;
		reg_wr_i && rate_hi_hit
		|=> rate_code_o[3] == $past(reg_wdata_i[5:3])
			&& rate_code_o[2] == $past(reg_wdata_i[2:0]);
	endproperty
	a_rate_pair: assert property (p_rate_pair)
		else $error("rate code fields misplaced");

	property p_in1_high;
		reg_wr_i && reg_addr_i == `IDR_IN1_DIV_HIGH
		|=> divider_value_o[0][18:16] == $past(reg_wdata_i[2:0])
			&& $stable(divider_value_o[1]);
	endproperty
	a_in1_high: assert property (p_in1_high)
		else $error("first input high bits not written");

	property p_alarm_low;
		rate_code_o[0] == 3'h0 && 11'(freq_mhz_i[0]) < 11'h00A
		|=> frequency_offset_alarm_o[0];
	endproperty
	a_alarm_low: assert property (p_alarm_low)
		else $error("no alarm below selected range");

	property p_reserved_zero;
		reg_rd_i && (reg_addr_i == `IDR_IN2_DIV_HIGH || rate_lo_hit)
		|=> reg_rdata_o[7:6] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits read non-zero");

	c_write_read: cover property (reg_wr_i && div_hit ##1 reg_rd_i);
	c_alarm_rise: cover property ($rose(frequency_offset_alarm_o[2]));
	c_reserved: cover property (rate_code_o[1] >= `IDR_RATE_RESERVED);

endmodule // idr_regs_bank
`default_nettype wire

// ---- test_input_divider_rate_regs.sv ----
// Self-checking bench for the divider and rate range register bank
`default_nettype none
`include "idr_regs.svh"
module test_input_divider_rate_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FW = 10;
	logic                          clock_i = 1'b0;
	logic                          arst_n_i = 1'b0;
	logic [7:0]                    reg_addr_i = 8'h00;
	logic [7:0]                    reg_wdata_i = 8'h00;
	logic                          reg_wr_i = 1'b0;
	logic                          reg_rd_i = 1'b0;
	logic [3:0][FW-1:0]            freq_mhz_i = '0;
	logic [7:0]                    reg_rdata_o;
	idr_pkg::idr_div_type   [3:0]  divider_value_o;
	idr_pkg::idr_ratio_type [3:0]  divide_ratio_o;
	idr_pkg::idr_rate_type  [3:0]  rate_code_o;
	logic [3:0]                    frequency_offset_alarm_o;
	int                            n_mismatch = 0;
	int                            cmp_count = 0;
	integer                        seed = 32'hCD28;
	logic [7:0]                    mem [8'h2B:8'h38];
	int                            lo_t [6] = '{10, 25, 50, 95, 190, 375};
	int                            hi_t [6] = '{27, 54, 105, 215, 435, 710};

	always #10 clock_i = ~clock_i;

	idr_regs_bank #(.FREQ_W(FW)) dut (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.freq_mhz_i(freq_mhz_i), .reg_rdata_o(reg_rdata_o),
		.divider_value_o(divider_value_o), .divide_ratio_o(divide_ratio_o),
		.rate_code_o(rate_code_o),
		.frequency_offset_alarm_o(frequency_offset_alarm_o)
	);

	////////////////////////////////////////
	// Expected values
	function automatic logic [7:0] msk(input logic [7:0] a);
		if (a < `IDR_IN1_DIV_HIGH || a > `IDR_RATE_IN3_IN4)
			return 8'h00;
		if (a >= `IDR_RATE_IN1_IN2)
			return 8'h3F;
		return ((a - `IDR_IN1_DIV_HIGH) % 3 == 0) ? 8'h07 : 8'hFF;
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		return (msk(a) == 8'h00) ? 8'h00 : mem[a];
	endfunction

	function automatic logic [18:0] exp_div(input int i);
		logic [7:0] b;
		b = `IDR_IN1_DIV_HIGH + 8'(3 * i);
		return {mem[b][2:0], mem[b + 8'h01], mem[b + 8'h02]};
	endfunction

	function automatic logic [2:0] exp_code(input int i);
		logic [7:0] r;
		r = mem[`IDR_RATE_IN1_IN2 + 8'(i / 2)] >> (3 * (i % 2));
		return r[2:0];
	endfunction

	function automatic logic exp_alarm(input logic [2:0] c, input logic [9:0] f);
		return (c > 3'h5) ? 1'b0 : (f < lo_t[c] || f > hi_t[c]);
	endfunction

	////////////////////////////////////////
	// Compare and bus tasks
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: output %h expected %h", $time, got, exp);
		end
	endtask

	task cyc;
		@(posedge clock_i);
		#1;
	endtask

	task automatic acc(input logic [7:0] a, d, input logic w, r);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = w;
		reg_rd_i = r;
		cyc;
		if (w && msk(a) != 8'h00)
			mem[a] = d & msk(a);
	endtask

	task idle;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		cyc;
	endtask

	task automatic check_outs;
		for (int i = 0; i < 4; i++)
		begin
			chk_out(20'(divider_value_o[i]), 20'(exp_div(i)));
			chk_out(divide_ratio_o[i], 20'(exp_div(i)) + 20'h1);
			chk_out(20'(rate_code_o[i]), 20'(exp_code(i)));
		end
	endtask

	task automatic do_reset;
		arst_n_i = 1'b0;
		for (int a = 8'h2B; a <= 8'h38; a++)
			mem[a] = ((a - 8'h2B) % 3 == 2 && a < 8'h37) ? 8'h09 : 8'h00;
		repeat (3) cyc;
		arst_n_i = 1'b1;
		cyc;
		for (int a = 8'h2A; a <= 8'h39; a++)
		begin
			acc(8'(a), 8'($random(seed)), 1'b0, 1'b1);
			idle;
			chk_byte(reg_rdata_o, exp_rd(8'(a)));
		end
		check_outs;
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// Scenarios
	initial
	begin
		logic [7:0]         a;
		logic [7:0]         e;
		logic [3:0][FW-1:0] fq;
		int                 f;
		logic               exp_al;
		do_reset;
		repeat (300)
		begin
			a = 8'h28 + 8'($unsigned($random(seed)) % 20);
			e = exp_rd(a);
			freq_mhz_i = 40'({$random(seed), $random(seed)});
			acc(a, 8'($random(seed)), 1'b1, 1'b1);
			idle;
			chk_byte(reg_rdata_o, e);
			check_outs;
		end
		do_reset;
		for (int c = 0; c < 8; c++)
		begin
			acc(`IDR_RATE_IN1_IN2, {2'b00, 3'(c), 3'(c)}, 1'b1, 1'b0);
			acc(`IDR_RATE_IN3_IN4, {2'b00, 3'(c), 3'(c)}, 1'b1, 1'b0);
			idle;
			for (int k = 0; k < 24; k++)
			begin
				f = (k % 4 < 2) ? lo_t[k/4] - 1 + k % 4 : hi_t[k/4] + k % 4 - 2;
				fq = 40'({$random(seed), $random(seed)});
				fq[c % 4] = 10'(f);
				freq_mhz_i = fq;
				cyc;
				cyc;
				for (int i = 0; i < 4; i++)
				begin
					exp_al = exp_alarm(exp_code(i), fq[i]);
					chk_out(20'(frequency_offset_alarm_o[i]), 20'(exp_al));
				end
			end
		end
		finish_test;
	end

	initial
	begin
		#100000;
		n_mismatch++;
		finish_test;
	end
endmodule // test_input_divider_rate_regs
`default_nettype wire
